// ### rtl/rfe_pkg.sv
package rfe_pkg;

  // Register offsets on the APB bus
  localparam logic [11:0] RFE_CTRL_OFS = 12'h000;
  localparam logic [11:0] RFE_STAT_OFS = 12'h004;
  localparam logic [11:0] RFE_CNT_OFS  = 12'h008;

  // Control field positions and reset values
  localparam int          RFE_CTRL_ROOT_BIT = 0;
  localparam int          RFE_CTRL_XINT_BIT = 1;
  localparam int          RFE_CTRL_CMPT_BIT = 2;
  localparam int          RFE_CTRL_IRTS_LSB = 4;
  localparam int          RFE_IRTS_W        = 4;
  localparam logic [31:0] RFE_CTRL_RST      = 32'h0000_0000;
  localparam logic [15:0] RFE_CNT_RST       = 16'h0000;
  localparam logic [15:0] RFE_CNT_MAX       = 16'hffff;

  // Table size encodings: largest value is 2^(field + base) - 1
  localparam int          RFE_PID_BASE  = 5;
  localparam int          RFE_IRTS_BASE = 1;

  // Fault reason codes
  typedef enum logic [7:0] {
    RFE_RSN_NONE      = 8'h00,
    RFE_RSN_SL_RSVD   = 8'h0c,
    RFE_RSN_TT_BLOCK  = 8'h0d,
    RFE_RSN_PID_DIS   = 8'h10,
    RFE_RSN_PID_BIG   = 8'h11,
    RFE_RSN_PE_ABSENT = 8'h12,
    RFE_RSN_PE_RSVD   = 8'h13,
    RFE_RSN_NONCANON  = 8'h14,
    RFE_RSN_TOP_ERR   = 8'h15,
    RFE_RSN_FL_RSVD   = 8'h16,
    RFE_RSN_LOW_ERR   = 8'h17,
    RFE_RSN_NO_EXEC   = 8'h18,
    RFE_RSN_EXE_OFF   = 8'h19,
    RFE_RSN_SUP_OFF   = 8'h1a,
    RFE_RSN_ROOT_TYPE = 8'h1b,
    RFE_RSN_IR_RSVD   = 8'h20,
    RFE_RSN_IR_INDEX  = 8'h21,
    RFE_RSN_IR_ABSENT = 8'h22,
    RFE_RSN_IR_FETCH  = 8'h23,
    RFE_RSN_INTERRUPT_REMAP_TABLE_ENTRY_RSVD = 8'h24,
    RFE_RSN_IR_COMPAT = 8'h25,
    RFE_RSN_IR_SRC    = 8'h26
  } rfe_reason_t;

  // Outcome of the DMA walk, one cycle of checks
  typedef struct packed {
    logic        is_pasid;
    logic        translated_req;
    logic        tt_blocked;
    logic        process_id_enable;
    logic [2:0]  process_id_table_size;
    logic [19:0] pasid;
    logic        pasid_entry_present;
    logic        pasid_entry_rsvd_nz;
    logic [63:0] addr;
    logic        top_fetch_err;
    logic        fl_rsvd_nz;
    logic        lower_fetch_err;
    logic        execute_requested;
    logic        exec_denied;
    logic        execute_request_enable;
    logic        privileged_mode_requested;
    logic        supervisor_request_enable;
    logic        sl_rsvd_nz;
  } rfe_dma_chk_t;

  // Outcome of the interrupt table lookup
  typedef struct packed {
    logic        compat_format;
    logic        rsvd_set;
    logic [15:0] index;
    logic        table_fetch_err;
    logic        interrupt_remap_table_entry_present;
    logic        interrupt_remap_table_entry_rsvd_nz;
    logic        source_identifier_fail;
  } rfe_irq_chk_t;

endpackage

// ### rtl/rfe_fault_encoder.sv
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps

// Contract
// - Blocked translation type reports 0Dh
// - PASID enable clear reports 10h
// - PASID beyond table size reports 11h
// - Absent PASID entry reports 12h
// - PASID entry reserved bits report 13h
// - Non-canonical address reports 14h
// - Top first-level fetch error reports 15h
// - First-level entry reserved bits report 16h
// - Lower first-level fetch error reports 17h
// - Execute permission missing reports 18h
// - Execute requests disabled report 19h
// - Supervisor requests disabled report 1Ah
// - Root table type clear reports 1Bh
// - Interrupt reserved bits report 20h
// - Interrupt index too large reports 21h
// - Absent remap entry reports 22h
// - Remap table fetch error reports 23h
// - Remap entry reserved bits report 24h
// - Blocked compatibility interrupt reports 25h
// - Source verification failure reports 26h
// - Second-level reserved bits report 0Ch
module rfe_fault_encoder
  import rfe_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         dma_chk_valid,
  input  wire rfe_dma_chk_t dma_chk,
  input  wire logic         irq_chk_valid,
  input  wire rfe_irq_chk_t irq_chk,
  output logic              irq_chk_ready,
  output logic              fault_valid,
  output logic              fault_is_irq,
  output logic      [7:0]   fault_reason
);

  // PASID larger than the table size allows
  function automatic logic pasid_too_big(input logic [19:0] pasid,
                                         input logic [2:0]  tsz);
    logic [5:0] sh;
    sh = 6'(tsz) + 6'(RFE_PID_BASE);
    pasid_too_big = (sh < 6'd20) && ((pasid >> sh) != 20'h0_0000);
  endfunction

  // Interrupt index larger than the table size allows
  function automatic logic index_too_big(input logic [15:0] idx,
                                         input logic [3:0]  irts);
    logic [5:0] sh;
    sh = 6'(irts) + 6'(RFE_IRTS_BASE);
    index_too_big = (sh < 6'd16) && ((idx >> sh) != 16'h0000);
  endfunction

  // Bits 63:48 must all copy bit 47
  function automatic logic non_canonical(input logic [63:0] a);
    non_canonical = (a[63:48] != {16{a[47]}});
  endfunction

  // Any code not listed in the enum is reserved
  function automatic logic reason_legal(input logic [7:0] r);
    case (r)
      8'h0c, 8'h0d, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
      8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h20, 8'h21,
      8'h22, 8'h23, 8'h24, 8'h25, 8'h26: reason_legal = 1'b1;
      default:                           reason_legal = 1'b0;
    endcase
  endfunction

  // Register state
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;

  // Fault output state
  logic        fault_valid_r;
  logic        fault_valid_nxt;
  logic        fault_is_irq_r;
  logic        fault_is_irq_nxt;
  logic [7:0]  fault_reason_r;
  logic [7:0]  fault_reason_nxt;

  // Decoded control bits
  logic                  root_table_type;
  logic                  extended_interrupt_mode_enable;
  logic                  compat_format_interrupt_status;
  logic [RFE_IRTS_W-1:0] irq_table_size;

  logic        setup_ph;
  logic        wr_en;
  logic        addr_hit;
  rfe_reason_t dma_rsn;
  rfe_reason_t irq_rsn;
  logic        irq_take;

  assign root_table_type                = ctrl_r[RFE_CTRL_ROOT_BIT];
  assign extended_interrupt_mode_enable = ctrl_r[RFE_CTRL_XINT_BIT];
  assign compat_format_interrupt_status = ctrl_r[RFE_CTRL_CMPT_BIT];
  assign irq_table_size = ctrl_r[RFE_CTRL_IRTS_LSB +: RFE_IRTS_W];

  // DMA and interrupt share one reason port; DMA wins a tie
  assign irq_chk_ready = !dma_chk_valid;
  assign irq_take      = irq_chk_valid && !dma_chk_valid;

  // APB: zero-wait access phase, data staged in setup
  assign setup_ph = psel && !penable;
  assign wr_en    = psel && penable && pwrite && !pslverr_r;
  assign addr_hit = (paddr == RFE_CTRL_OFS) || (paddr == RFE_STAT_OFS) ||
                    (paddr == RFE_CNT_OFS);
  assign pready   = 1'b1;
  assign prdata   = prdata_r;
  assign pslverr  = pslverr_r;

  // DMA fault classification, walk order sets the priority
  always_comb begin
    dma_rsn = RFE_RSN_NONE;
    if (!dma_chk.is_pasid) begin
      if (dma_chk.translated_req && dma_chk.tt_blocked) begin
        dma_rsn = RFE_RSN_TT_BLOCK;
      end else if (dma_chk.sl_rsvd_nz) begin
        dma_rsn = RFE_RSN_SL_RSVD;
      end
    end else if (!root_table_type) begin
      dma_rsn = RFE_RSN_ROOT_TYPE;
    end else if (dma_chk.translated_req) begin
      // Translated requests skip the PASID table walk
      if (dma_chk.tt_blocked) begin
        dma_rsn = RFE_RSN_TT_BLOCK;
      end else if (dma_chk.execute_requested && !dma_chk.execute_request_enable) begin
        dma_rsn = RFE_RSN_EXE_OFF;
      end else if (dma_chk.privileged_mode_requested &&
                   !dma_chk.supervisor_request_enable) begin
        dma_rsn = RFE_RSN_SUP_OFF;
      end else if (non_canonical(dma_chk.addr)) begin
        dma_rsn = RFE_RSN_NONCANON;
      end
    end else if (!dma_chk.process_id_enable) begin
      dma_rsn = RFE_RSN_PID_DIS;
    end else if (pasid_too_big(dma_chk.pasid, dma_chk.process_id_table_size)) begin
      dma_rsn = RFE_RSN_PID_BIG;
    end else if (dma_chk.execute_requested && !dma_chk.execute_request_enable) begin
      dma_rsn = RFE_RSN_EXE_OFF;
    end else if (dma_chk.privileged_mode_requested &&
                 !dma_chk.supervisor_request_enable) begin
      dma_rsn = RFE_RSN_SUP_OFF;
    end else if (non_canonical(dma_chk.addr)) begin
      dma_rsn = RFE_RSN_NONCANON;
    end else if (!dma_chk.pasid_entry_present) begin
      dma_rsn = RFE_RSN_PE_ABSENT;
    end else if (dma_chk.pasid_entry_rsvd_nz) begin
      dma_rsn = RFE_RSN_PE_RSVD;
    end else if (dma_chk.top_fetch_err) begin
      dma_rsn = RFE_RSN_TOP_ERR;
    end else if (dma_chk.lower_fetch_err) begin
      dma_rsn = RFE_RSN_LOW_ERR;
    end else if (dma_chk.fl_rsvd_nz) begin
      dma_rsn = RFE_RSN_FL_RSVD;
    end else if (dma_chk.execute_requested && dma_chk.exec_denied) begin
      dma_rsn = RFE_RSN_NO_EXEC;
    end
  end

  // Interrupt fault classification
  always_comb begin
    irq_rsn = RFE_RSN_NONE;
    if (irq_chk.compat_format) begin
      // Compatibility requests bypass the table when allowed
      if (extended_interrupt_mode_enable || !compat_format_interrupt_status) begin
        irq_rsn = RFE_RSN_IR_COMPAT;
      end
    end else if (irq_chk.rsvd_set) begin
      irq_rsn = RFE_RSN_IR_RSVD;
    end else if (index_too_big(irq_chk.index, irq_table_size)) begin
      irq_rsn = RFE_RSN_IR_INDEX;
    end else if (irq_chk.table_fetch_err) begin
      irq_rsn = RFE_RSN_IR_FETCH;
    end else if (!irq_chk.interrupt_remap_table_entry_present) begin
      irq_rsn = RFE_RSN_IR_ABSENT;
    end else if (irq_chk.interrupt_remap_table_entry_rsvd_nz) begin
      irq_rsn = RFE_RSN_INTERRUPT_REMAP_TABLE_ENTRY_RSVD;
    end else if (irq_chk.source_identifier_fail) begin
      irq_rsn = RFE_RSN_IR_SRC;
    end
  end

  // Fault output next state; reserved codes can never leave
  always_comb begin
    fault_valid_nxt  = 1'b0;
    fault_is_irq_nxt = fault_is_irq_r;
    fault_reason_nxt = fault_reason_r;
    if (dma_chk_valid && dma_rsn != RFE_RSN_NONE) begin
      fault_valid_nxt  = reason_legal(dma_rsn);
      fault_is_irq_nxt = 1'b0;
      fault_reason_nxt = dma_rsn;
    end else if (irq_take && irq_rsn != RFE_RSN_NONE) begin
      fault_valid_nxt  = reason_legal(irq_rsn);
      fault_is_irq_nxt = 1'b1;
      fault_reason_nxt = irq_rsn;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_valid_r  <= 1'b0;
      fault_is_irq_r <= 1'b0;
      fault_reason_r <= RFE_RSN_NONE;
    end else begin
      fault_valid_r  <= fault_valid_nxt;
      fault_is_irq_r <= fault_is_irq_nxt;
      fault_reason_r <= fault_reason_nxt;
    end
  end

  assign fault_valid  = fault_valid_r;
  assign fault_is_irq = fault_is_irq_r;
  assign fault_reason = fault_reason_r;

  // Register file next state; a fault in the counter clear cycle counts from zero
  always_comb begin
    ctrl_nxt    = ctrl_r;
    cnt_nxt     = cnt_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    if (wr_en && paddr == RFE_CTRL_OFS) begin
      ctrl_nxt = pwdata & 32'h0000_00f7;
    end
    if (wr_en && paddr == RFE_CNT_OFS) begin
      cnt_nxt = RFE_CNT_RST;
    end
    if (fault_valid_r && cnt_nxt != RFE_CNT_MAX) begin
      cnt_nxt = cnt_nxt + 16'h0001;
    end
    if (setup_ph) begin
      pslverr_nxt = !addr_hit;
      case (paddr)
        RFE_CTRL_OFS: prdata_nxt = ctrl_r;
        RFE_STAT_OFS: prdata_nxt = {23'h00_0000, fault_is_irq_r, fault_reason_r};
        RFE_CNT_OFS:  prdata_nxt = {16'h0000, cnt_r};
        default:      prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= RFE_CTRL_RST;
      cnt_r     <= RFE_CNT_RST;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      cnt_r     <= cnt_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Checks, all on pclk
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic pasid_go;
  logic untr_go;
  assign pasid_go = dma_chk_valid && dma_chk.is_pasid && root_table_type;
  assign untr_go  = pasid_go && !dma_chk.translated_req;

  sequence s_fault(logic [7:0] r);
    fault_valid && !fault_is_irq && fault_reason == r;
  endsequence

  sequence s_irq_fault(logic [7:0] r);
    fault_valid && fault_is_irq && fault_reason == r;
  endsequence

  sequence s_quiet;
    !fault_valid;
  endsequence

  AST_TT_BLOCK: assert property (
    dma_chk_valid && dma_chk.translated_req && dma_chk.tt_blocked &&
    (!dma_chk.is_pasid || root_table_type) |=> s_fault(RFE_RSN_TT_BLOCK))
    else $error("blocked translation type not reported");

  AST_PID_DIS: assert property (
    untr_go && !dma_chk.process_id_enable |=> s_fault(RFE_RSN_PID_DIS))
    else $error("disabled process id not reported");

  AST_ROOT_TYPE: assert property (
    dma_chk_valid && dma_chk.is_pasid && !root_table_type
    |=> s_fault(RFE_RSN_ROOT_TYPE))
    else $error("root table type fault not reported");

  AST_NONCANON: assert property (
    untr_go && dma_chk.process_id_enable &&
    !pasid_too_big(dma_chk.pasid, dma_chk.process_id_table_size) &&
    !(dma_chk.execute_requested && !dma_chk.execute_request_enable) &&
    !(dma_chk.privileged_mode_requested && !dma_chk.supervisor_request_enable) &&
    non_canonical(dma_chk.addr) |=> s_fault(RFE_RSN_NONCANON))
    else $error("non-canonical address not reported");

  AST_SL_RSVD: assert property (
    dma_chk_valid && !dma_chk.is_pasid && dma_chk.sl_rsvd_nz &&
    !(dma_chk.translated_req && dma_chk.tt_blocked)
    |=> s_fault(RFE_RSN_SL_RSVD))
    else $error("second-level reserved fault not reported");

  AST_COMPAT: assert property (
    irq_take && irq_chk.compat_format &&
    (extended_interrupt_mode_enable || !compat_format_interrupt_status)
    |=> s_irq_fault(RFE_RSN_IR_COMPAT))
    else $error("blocked compatibility interrupt not reported");

  AST_COMPAT_PASS: assert property (
    irq_take && irq_chk.compat_format && !extended_interrupt_mode_enable &&
    compat_format_interrupt_status |=> s_quiet)
    else $error("allowed compatibility interrupt faulted");

  AST_IR_RSVD: assert property (
    irq_take && !irq_chk.compat_format && irq_chk.rsvd_set
    |=> s_irq_fault(RFE_RSN_IR_RSVD))
    else $error("interrupt reserved fault not reported");

  AST_IR_SRC: assert property (
    irq_take && !irq_chk.compat_format && !irq_chk.rsvd_set &&
    !index_too_big(irq_chk.index, irq_table_size) && !irq_chk.table_fetch_err &&
    irq_chk.interrupt_remap_table_entry_present && !irq_chk.interrupt_remap_table_entry_rsvd_nz && irq_chk.source_identifier_fail
    |=> s_irq_fault(RFE_RSN_IR_SRC))
    else $error("source verification fault not reported");

  AST_PID_BIG: assert property (
    untr_go && dma_chk.process_id_enable &&
    pasid_too_big(dma_chk.pasid, dma_chk.process_id_table_size)
    |=> s_fault(RFE_RSN_PID_BIG))
    else $error("oversized process id not reported");

  AST_EXE_OFF: assert property (
    untr_go && dma_chk.process_id_enable &&
    !pasid_too_big(dma_chk.pasid, dma_chk.process_id_table_size) &&
    dma_chk.execute_requested && !dma_chk.execute_request_enable
    |=> s_fault(RFE_RSN_EXE_OFF))
    else $error("disabled execute request not reported");

  // Missing execute permission only faults untranslated requests
  AST_NO_EXEC_TRANS: assert property (
    pasid_go && dma_chk.translated_req |=> not s_fault(RFE_RSN_NO_EXEC))
    else $error("execute fault on translated request");

  AST_IR_INDEX: assert property (
    irq_take && !irq_chk.compat_format && !irq_chk.rsvd_set &&
    index_too_big(irq_chk.index, irq_table_size) |=> s_irq_fault(RFE_RSN_IR_INDEX))
    else $error("interrupt index fault not reported");

  // Listed independently of the encoder's own legality function
  AST_LEGAL: assert property (
    fault_valid |-> fault_reason inside {[8'h0c:8'h0d], [8'h10:8'h1b], [8'h20:8'h26]})
    else $error("reserved fault reason emitted");

  AST_ONE_SHOT: assert property (
    !dma_chk_valid && !irq_chk_valid |=> s_quiet)
    else $error("fault without a request");

endmodule // rfe_fault_encoder

// ### tb/rfe_req_model.sv
`timescale 1ns/1ps

// Requester side: presents walk results and interrupt lookup results
module rfe_req_model
  import rfe_pkg::*;
(
  input  wire logic   pclk,
  input  wire logic   irq_chk_ready,
  output logic        dma_chk_valid,
  output rfe_dma_chk_t dma_chk,
  output logic        irq_chk_valid,
  output rfe_irq_chk_t irq_chk
);
  // Idle at time zero
  initial begin
    dma_chk_valid = 1'b0;
    dma_chk       = '0;
    irq_chk_valid = 1'b0;
    irq_chk       = '0;
  end

  // One walk result per call, back to back when called at each edge
  task automatic send_dma(input rfe_dma_chk_t s);
    @(posedge pclk);
    dma_chk_valid <= 1'b1;
    dma_chk       <= s;
  endtask

  // Released lines flip so a stale value is never taken for data
  task automatic idle_dma();
    @(posedge pclk);
    dma_chk_valid <= 1'b0;
    dma_chk       <= ~dma_chk;
  endtask

  // Held until taken, since a walk result blocks the lookup
  // Only the bench watchdog ends a wait that never completes
  task automatic send_irq(input rfe_irq_chk_t s);
    @(posedge pclk);
    irq_chk_valid <= 1'b1;
    irq_chk       <= s;
    do begin
      @(posedge pclk);
    end while (irq_chk_ready !== 1'b1);
    irq_chk_valid <= 1'b0;
    irq_chk       <= ~s;
  endtask
endmodule // rfe_req_model

// ### tb/test_remap_fault_reason_encoder.sv
`timescale 1ns/1ps

module test_remap_fault_reason_encoder
  import rfe_pkg::*;
;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd, rw;
  logic         dma_chk_valid, irq_chk_valid, irq_chk_ready;
  logic         fault_valid, fault_is_irq, he;
  logic [7:0]   fault_reason, ec;
  rfe_dma_chk_t dma_chk, db, d;
  rfe_irq_chk_t irq_chk, ib, q;
  logic [8:0]   exp_q[$];
  int           err_total, check_count, fault_cnt;

  rfe_fault_encoder i_rfe_fault_encoder (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dma_chk_valid(dma_chk_valid), .dma_chk(dma_chk),
    .irq_chk_valid(irq_chk_valid), .irq_chk(irq_chk), .irq_chk_ready(irq_chk_ready),
    .fault_valid(fault_valid), .fault_is_irq(fault_is_irq), .fault_reason(fault_reason));

  rfe_req_model i_rfe_req_model (.pclk(pclk), .irq_chk_ready(irq_chk_ready),
    .dma_chk_valid(dma_chk_valid), .dma_chk(dma_chk), .irq_chk_valid(irq_chk_valid),
    .irq_chk(irq_chk));

  // 100 MHz clock
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  task automatic bad(input string msg);
    $display("BAD %0t %s", $time, msg);
    err_total++;
  endtask

  task automatic cmp_code(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) bad($sformatf("fault %h expected %h", got, exp));
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) bad($sformatf("read %h expected %h", got, exp));
  endtask

  // One APB transfer; waits on pready rather than assuming zero wait
  task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= is_wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
    cmp_word({31'h0, e}, 32'h0);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    cmp_word(rd, x);
    cmp_word({31'h0, e}, {31'h0, xe});
  endtask

  // Expected faults are noted before the request goes out
  task automatic note(input logic irq, input logic [7:0] code);
    exp_q.push_back({irq, code});
    fault_cnt++;
  endtask

  task automatic finish_test();
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Every fault pulse must match the oldest note
  always @(posedge pclk) begin
    if (fault_valid === 1'b1) begin
      if (exp_q.size() == 0) bad("unexpected fault");
      else cmp_code({fault_is_irq, fault_reason}, exp_q.pop_front());
    end
  end

  // Watchdog, far beyond the hundred or so cycles the run needs
  initial begin
    #200000;
    bad("timeout");
    finish_test();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    err_total = 0;
    check_count = 0;
    fault_cnt = 0;
    void'($urandom(32'h3437));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(RFE_CTRL_OFS, 32'h0, 1'b0);
    rdc(RFE_CNT_OFS, 32'h0, 1'b0);
    rdc(12'h00c, 32'h0, 1'b1);
    // Clean PASID walk, but root table type still clear
    db = '0;
    db.is_pasid = 1'b1;
    db.process_id_enable = 1'b1;
    db.pasid_entry_present = 1'b1;
    db.execute_request_enable = 1'b1;
    db.supervisor_request_enable = 1'b1;
    note(1'b0, RFE_RSN_ROOT_TYPE);
    i_rfe_req_model.send_dma(db);
    i_rfe_req_model.idle_dma();
    wr(RFE_CTRL_OFS, 32'hffff_ffff);
    rdc(RFE_CTRL_OFS, 32'h0000_00f7, 1'b0);
    wr(RFE_CTRL_OFS, 32'h0000_0005);
    // At most one fault per walk, sent back to back; table size 0 allows 0..31
    for (int i = 0; i < 19; i++) begin
      d = db;
      d.pasid = 20'($urandom % 32);
      he = 1'b1;
      case (i)
        0: begin d.pasid = 20'h1f; he = 1'b0; end
        1: begin d.translated_req = 1'b1; d.tt_blocked = 1'b1; ec = RFE_RSN_TT_BLOCK; end
        2: begin d.process_id_enable = 1'b0; ec = RFE_RSN_PID_DIS; end
        3: begin d.pasid = 20'h20; ec = RFE_RSN_PID_BIG; end
        4: begin d.pasid_entry_present = 1'b0; ec = RFE_RSN_PE_ABSENT; end
        5: begin d.pasid_entry_rsvd_nz = 1'b1; ec = RFE_RSN_PE_RSVD; end
        6: begin d.addr = 64'h0000_8000_0000_0000; ec = RFE_RSN_NONCANON; end
        7: begin d.addr = 64'hffff_8000_0000_0000; he = 1'b0; end
        8: begin d.top_fetch_err = 1'b1; ec = RFE_RSN_TOP_ERR; end
        9: begin d.fl_rsvd_nz = 1'b1; ec = RFE_RSN_FL_RSVD; end
        10: begin d.lower_fetch_err = 1'b1; ec = RFE_RSN_LOW_ERR; end
        11: begin d.execute_requested = 1'b1; d.exec_denied = 1'b1; ec = RFE_RSN_NO_EXEC; end
        12: begin d.execute_requested = 1'b1; d.execute_request_enable = 1'b0; ec = RFE_RSN_EXE_OFF; end
        13: begin d.privileged_mode_requested = 1'b1; d.supervisor_request_enable = 1'b0; ec = RFE_RSN_SUP_OFF; end
        14: begin d.is_pasid = 1'b0; d.translated_req = 1'b1; d.tt_blocked = 1'b1; ec = RFE_RSN_TT_BLOCK; end
        15: begin d.is_pasid = 1'b0; d.sl_rsvd_nz = 1'b1; ec = RFE_RSN_SL_RSVD; end
        16: begin d.translated_req = 1'b1; d.execute_requested = 1'b1; d.exec_denied = 1'b1; he = 1'b0; end
        17: begin d.process_id_table_size = 3'h3; d.pasid = 20'h100; ec = RFE_RSN_PID_BIG; end
        default: begin d.process_id_table_size = 3'h3; d.pasid = 20'h0ff; he = 1'b0; end
      endcase
      if (he) note(1'b0, ec);
      i_rfe_req_model.send_dma(d);
    end
    i_rfe_req_model.idle_dma();
    // Interrupt lookups; table size 0 allows index 0..1
    ib = '0;
    ib.interrupt_remap_table_entry_present = 1'b1;
    for (int i = 0; i < 8; i++) begin
      q = ib;
      q.index = 16'($urandom % 2);
      he = 1'b1;
      case (i)
        0: he = 1'b0;
        1: begin q.rsvd_set = 1'b1; ec = RFE_RSN_IR_RSVD; end
        2: begin q.index = 16'h2; ec = RFE_RSN_IR_INDEX; end
        3: begin q.table_fetch_err = 1'b1; ec = RFE_RSN_IR_FETCH; end
        4: begin q.interrupt_remap_table_entry_present = 1'b0; ec = RFE_RSN_IR_ABSENT; end
        5: begin q.interrupt_remap_table_entry_rsvd_nz = 1'b1; ec = RFE_RSN_INTERRUPT_REMAP_TABLE_ENTRY_RSVD; end
        6: begin q.source_identifier_fail = 1'b1; ec = RFE_RSN_IR_SRC; end
        default: begin q.compat_format = 1'b1; he = 1'b0; end
      endcase
      if (he) note(1'b1, ec);
      i_rfe_req_model.send_irq(q);
    end
    // Control settings that change the outcome
    for (int j = 0; j < 4; j++) begin
      q = ib;
      case (j)
        0: begin rw = 32'h1; q.compat_format = 1'b1; he = 1'b1; ec = RFE_RSN_IR_COMPAT; end
        1: begin rw = 32'h7; q.compat_format = 1'b1; he = 1'b1; ec = RFE_RSN_IR_COMPAT; end
        2: begin rw = 32'h35; q.index = 16'hf; he = 1'b0; end
        default: begin rw = 32'h35; q.index = 16'h10; he = 1'b1; ec = RFE_RSN_IR_INDEX; end
      endcase
      wr(RFE_CTRL_OFS, rw);
      if (he) note(1'b1, ec);
      i_rfe_req_model.send_irq(q);
    end
    // Lookup offered beside a walk must wait and still be classified
    d = db;
    d.privileged_mode_requested = 1'b1;
    d.supervisor_request_enable = 1'b0;
    q = ib;
    q.rsvd_set = 1'b1;
    note(1'b0, RFE_RSN_SUP_OFF);
    note(1'b1, RFE_RSN_IR_RSVD);
    fork
      begin
        i_rfe_req_model.send_dma(d);
        i_rfe_req_model.idle_dma();
      end
      i_rfe_req_model.send_irq(q);
    join
    repeat (3) @(posedge pclk);
    wr(RFE_STAT_OFS, 32'hffff_ffff);
    rdc(RFE_STAT_OFS, 32'h0000_0120, 1'b0);
    rdc(RFE_CNT_OFS, 32'(fault_cnt), 1'b0);
    wr(RFE_CNT_OFS, 32'h0);
    rdc(RFE_CNT_OFS, 32'h0, 1'b0);
    cmp_word(32'(exp_q.size()), 32'h0);
    finish_test();
  end
endmodule // test_remap_fault_reason_encoder
